// ==== logic/amr_alert_mask_regs.sv ====
// Alert mask bank, identification registers and their management-bus slave.
//
// Contract
// (R1) Host leaves the second factory test register alone in normal use.
// (R2) Identification register at its offset returns the maker code.
// (R3) Revision low nibble is minor revision, zero for first, counting up.
// (R4) Revision high nibble is a fixed generation code.
// (R5) First mask suppresses remote temps, shared input nine and six supply rails.
// (R6) Second mask bit n suppresses general analog input n.
// (R7) Third mask bit n suppresses tach input n.
// (R8) Fourth mask bits 0-2 suppress internal temp, battery, analog input eight.
// (R9) Fourth mask bit 3 suppresses thermal alarm pin events.
// (R10) Fourth mask bit 4 suppresses automatic fan control events.
// (R11) Fourth mask bit 5 is unused and always reads zero.
// (R12) Fourth mask bit 6 suppresses chassis intrusion events.
// (R13) Fourth mask bit 7 suppresses general io line sixteen.
// (R14) Fifth mask bit n suppresses general io line n.
// (R15) All mask registers clear to zero at reset.
// (R16) Sixth mask bit n suppresses general io line eight plus n.
// (R17) Status flag set when last conversion was out of limits, else zero.
// (R18) Alert asserts while any status flag is set with mask clear.
// (R19) Masking affects only the alert; status flags still set and read.
module amr_alert_mask_regs
    import amr_pkg::*;
#(
    parameter logic [6:0] P_SMBUS_ADDR = AMR_SMBUS_ADDR_DEFAULT,
    parameter logic [7:0] P_MAKER_ID = AMR_MAKER_ID_DEFAULT,
    parameter logic [3:0] P_REV_MAJOR = AMR_REV_MAJOR_DEFAULT,
    parameter logic [3:0] P_REV_MINOR = AMR_REV_MINOR_DEFAULT
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Management bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // Limit comparison results, taken at conversion end
    input wire logic i_conv_done,
    input wire logic [7:0] i_fault_temp_supplies,
    input wire logic [7:0] i_fault_analog_inputs,
    input wire logic [7:0] i_fault_fan_tach,
    input wire logic [7:0] i_fault_misc_events,
    input wire logic [7:0] i_fault_io_low,
    input wire logic [7:0] i_fault_io_high,
    // Status flags, unaffected by masking
    output logic [7:0] o_status_temp_supplies,
    output logic [7:0] o_status_analog_inputs,
    output logic [7:0] o_status_fan_tach,
    output logic [7:0] o_status_misc_events,
    output logic [7:0] o_status_io_low,
    output logic [7:0] o_status_io_high,
    // Alert interrupt, active low
    output logic o_alert_n
);

    amr_state_t state_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic master_ack_reg;
    logic sda_oe_n_reg;
    logic sda_out_reg;
    logic wr_stb_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] rd_byte;

    logic [7:0] factory_test_two_reg;
    logic [7:0] irq_mask_temp_supplies_reg;
    logic [7:0] irq_mask_analog_inputs_reg;
    logic [7:0] irq_mask_fan_tach_reg;
    logic [7:0] irq_mask_misc_events_reg;
    logic [7:0] irq_mask_io_low_reg;
    logic [7:0] irq_mask_io_high_reg;

    logic [7:0] st_temp_supplies_reg;
    logic [7:0] st_analog_inputs_reg;
    logic [7:0] st_fan_tach_reg;
    logic [7:0] st_misc_events_reg;
    logic [7:0] st_io_low_reg;
    logic [7:0] st_io_high_reg;
    logic alert_n_reg;
    logic alert_n_next;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic byte_done;

    // Bus line edges, pins taken as synchronous
    assign scl_rise = i_scl & ~scl_prev_reg;
    assign scl_fall = ~i_scl & scl_prev_reg;
    assign bus_start = scl_prev_reg & i_scl & sda_prev_reg & ~i_sda;
    assign bus_stop = scl_prev_reg & i_scl & ~sda_prev_reg & i_sda;
    assign byte_done = scl_fall && (bit_cnt_reg == AMR_BITS_PER_BYTE);

    // Read decode, shared by first and following read bytes
    function automatic logic [7:0] amr_read_mux(input logic [7:0] ofs);
        logic [7:0] data;
        data = AMR_UNMAPPED_READ;
        unique case (ofs)
            AMR_OFS_FACTORY_TEST_TWO: data = factory_test_two_reg;
            // (R2) maker code readback
            AMR_OFS_MAKER_ID: data = P_MAKER_ID;
            // (R3) minor revision nibble
            // (R4) generation nibble
            AMR_OFS_SILICON_REV: data = {P_REV_MAJOR, P_REV_MINOR};
            AMR_OFS_MASK_TEMP_SUPPLIES: data = irq_mask_temp_supplies_reg;
            AMR_OFS_MASK_ANALOG_INPUTS: data = irq_mask_analog_inputs_reg;
            AMR_OFS_MASK_FAN_TACH: data = irq_mask_fan_tach_reg;
            // (R11) unused bit reads zero
            AMR_OFS_MASK_MISC_EVENTS: data = irq_mask_misc_events_reg & AMR_MISC_USED_BITS;
            AMR_OFS_MASK_IO_LOW: data = irq_mask_io_low_reg;
            AMR_OFS_MASK_IO_HIGH: data = irq_mask_io_high_reg;
            default: data = AMR_UNMAPPED_READ;
        endcase
        return data;
    endfunction : amr_read_mux

    // Function reads registers too, so recompute on any change
    always_comb begin
        rd_byte = amr_read_mux(ptr_reg);
    end

    // Line history for edge detection
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= i_scl;
            sda_prev_reg <= i_sda;
        end
    end

    // Byte-level slave: write byte and read byte with repeated start
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= AMR_ST_IDLE;
            bit_cnt_reg <= AMR_CNT_ZERO;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            wr_stb_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            sda_out_reg <= 1'b0;
        end else begin
            wr_stb_reg <= 1'b0;
            sda_out_reg <= 1'b0;
            if (bus_stop) begin
                state_reg <= AMR_ST_IDLE;
                sda_oe_n_reg <= 1'b1;
            end else if (bus_start) begin
                // Repeated start keeps the pointer for a following read
                state_reg <= AMR_ST_ADDR;
                bit_cnt_reg <= AMR_CNT_ZERO;
                sda_oe_n_reg <= 1'b1;
            end else begin
                unique case (state_reg)
                    AMR_ST_IDLE: begin
                        sda_oe_n_reg <= 1'b1;
                    end
                    AMR_ST_ADDR, AMR_ST_CMD, AMR_ST_WDATA: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], i_sda};
                            bit_cnt_reg <= bit_cnt_reg + AMR_CNT_ONE;
                        end else if (byte_done) begin
                            bit_cnt_reg <= AMR_CNT_ZERO;
                            sda_oe_n_reg <= 1'b0;
                            if (state_reg == AMR_ST_ADDR) begin
                                rw_reg <= shift_reg[0];
                                if (shift_reg[7:1] == P_SMBUS_ADDR) begin
                                    state_reg <= AMR_ST_ADDR_ACK;
                                end else begin
                                    // Not ours: stay off the line
                                    state_reg <= AMR_ST_IDLE;
                                    sda_oe_n_reg <= 1'b1;
                                end
                            end else if (state_reg == AMR_ST_CMD) begin
                                ptr_reg <= shift_reg;
                                state_reg <= AMR_ST_CMD_ACK;
                            end else begin
                                wr_stb_reg <= 1'b1;
                                wr_data_reg <= shift_reg;
                                state_reg <= AMR_ST_WDAT_ACK;
                            end
                        end
                    end
                    AMR_ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= AMR_CNT_ZERO;
                            if (rw_reg) begin
                                tx_reg <= {rd_byte[6:0], 1'b0};
                                sda_oe_n_reg <= rd_byte[7];
                                state_reg <= AMR_ST_RDATA;
                            end else begin
                                sda_oe_n_reg <= 1'b1;
                                state_reg <= AMR_ST_CMD;
                            end
                        end
                    end
                    AMR_ST_CMD_ACK, AMR_ST_WDAT_ACK: begin
                        // Extra bytes rewrite the same register
                        if (scl_fall) begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= AMR_ST_WDATA;
                        end
                    end
                    AMR_ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + AMR_CNT_ONE;
                        end else if (byte_done) begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= AMR_ST_RDAT_ACK;
                        end else if (scl_fall) begin
                            sda_oe_n_reg <= tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                    AMR_ST_RDAT_ACK: begin
                        if (scl_rise) begin
                            master_ack_reg <= ~i_sda;
                        end else if (scl_fall) begin
                            bit_cnt_reg <= AMR_CNT_ZERO;
                            if (master_ack_reg) begin
                                tx_reg <= {rd_byte[6:0], 1'b0};
                                sda_oe_n_reg <= rd_byte[7];
                                state_reg <= AMR_ST_RDATA;
                            end else begin
                                state_reg <= AMR_ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Register writes; identity and revision ignore writes
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            factory_test_two_reg <= AMR_FACTORY_TEST_RESET;
            // (R15) masks clear at reset
            irq_mask_temp_supplies_reg <= AMR_MASK_RESET;
            irq_mask_analog_inputs_reg <= AMR_MASK_RESET;
            irq_mask_fan_tach_reg <= AMR_MASK_RESET;
            irq_mask_misc_events_reg <= AMR_MASK_RESET;
            irq_mask_io_low_reg <= AMR_MASK_RESET;
            irq_mask_io_high_reg <= AMR_MASK_RESET;
        end else if (wr_stb_reg) begin
            unique case (ptr_reg)
                // (R1) plain storage, no test side effects
                AMR_OFS_FACTORY_TEST_TWO: factory_test_two_reg <= wr_data_reg;
                AMR_OFS_MASK_TEMP_SUPPLIES: irq_mask_temp_supplies_reg <= wr_data_reg;
                AMR_OFS_MASK_ANALOG_INPUTS: irq_mask_analog_inputs_reg <= wr_data_reg;
                AMR_OFS_MASK_FAN_TACH: irq_mask_fan_tach_reg <= wr_data_reg;
                // (R11) unused bit never stored
                AMR_OFS_MASK_MISC_EVENTS: begin
                    irq_mask_misc_events_reg <= wr_data_reg & AMR_MISC_USED_BITS;
                end
                AMR_OFS_MASK_IO_LOW: irq_mask_io_low_reg <= wr_data_reg;
                AMR_OFS_MASK_IO_HIGH: irq_mask_io_high_reg <= wr_data_reg;
                default: begin
                end
            endcase
        end
    end

    // (R17) flags follow last conversion result
    // (R19) capture ignores the masks
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            st_temp_supplies_reg <= AMR_STATUS_RESET;
            st_analog_inputs_reg <= AMR_STATUS_RESET;
            st_fan_tach_reg <= AMR_STATUS_RESET;
            st_misc_events_reg <= AMR_STATUS_RESET;
            st_io_low_reg <= AMR_STATUS_RESET;
            st_io_high_reg <= AMR_STATUS_RESET;
        end else if (i_conv_done) begin
            st_temp_supplies_reg <= i_fault_temp_supplies;
            st_analog_inputs_reg <= i_fault_analog_inputs;
            st_fan_tach_reg <= i_fault_fan_tach;
            st_misc_events_reg <= i_fault_misc_events & AMR_MISC_USED_BITS;
            st_io_low_reg <= i_fault_io_low;
            st_io_high_reg <= i_fault_io_high;
        end
    end

    // Alert from unmasked flags
    always_comb begin
        // (R5) rails and remote temps
        // (R6) general analog inputs
        // (R7) tach inputs
        // (R8) internal temp, battery, input eight
        // (R9) thermal pin, bit 3
        // (R10) fan control, bit 4
        // (R12) chassis intrusion, bit 6
        // (R13) io line sixteen, bit 7
        // (R14) io lines zero to seven
        // (R16) io lines eight to fifteen
        // (R18) any unmasked flag alerts
        alert_n_next = ~(|(st_temp_supplies_reg & ~irq_mask_temp_supplies_reg)
            | |(st_analog_inputs_reg & ~irq_mask_analog_inputs_reg)
            | |(st_fan_tach_reg & ~irq_mask_fan_tach_reg)
            | |(st_misc_events_reg & ~irq_mask_misc_events_reg)
            | |(st_io_low_reg & ~irq_mask_io_low_reg)
            | |(st_io_high_reg & ~irq_mask_io_high_reg));
    end

    // Registered so the pin never glitches on mask writes
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            alert_n_reg <= 1'b1;
        end else begin
            alert_n_reg <= alert_n_next;
        end
    end

    assign o_sda_out = sda_out_reg;
    assign o_sda_oe_n = sda_oe_n_reg;
    assign o_alert_n = alert_n_reg;
    assign o_status_temp_supplies = st_temp_supplies_reg;
    assign o_status_analog_inputs = st_analog_inputs_reg;
    assign o_status_fan_tach = st_fan_tach_reg;
    assign o_status_misc_events = st_misc_events_reg;
    assign o_status_io_low = st_io_low_reg;
    assign o_status_io_high = st_io_high_reg;

endmodule : amr_alert_mask_regs

// ==== logic/amr_pkg.sv ====
// Constants, offsets and state codes for the alert mask and identification bank.
package amr_pkg;

    // Register offsets on the management bus
    localparam logic [7:0] AMR_OFS_FACTORY_TEST_TWO = 8'h15;
    localparam logic [7:0] AMR_OFS_MAKER_ID = 8'h16;
    localparam logic [7:0] AMR_OFS_SILICON_REV = 8'h17;
    localparam logic [7:0] AMR_OFS_MASK_TEMP_SUPPLIES = 8'h18;
    localparam logic [7:0] AMR_OFS_MASK_ANALOG_INPUTS = 8'h19;
    localparam logic [7:0] AMR_OFS_MASK_FAN_TACH = 8'h1A;
    localparam logic [7:0] AMR_OFS_MASK_MISC_EVENTS = 8'h1B;
    localparam logic [7:0] AMR_OFS_MASK_IO_LOW = 8'h1C;
    localparam logic [7:0] AMR_OFS_MASK_IO_HIGH = 8'h1D;

    // Reset values
    localparam logic [7:0] AMR_MASK_RESET = 8'h00;
    localparam logic [7:0] AMR_FACTORY_TEST_RESET = 8'h00;
    localparam logic [7:0] AMR_STATUS_RESET = 8'h00;
    localparam logic [7:0] AMR_UNMAPPED_READ = 8'h00;

    // Misc events mask: bit 5 has no function and reads zero
    localparam logic [7:0] AMR_MISC_USED_BITS = 8'hDF;

    // Identity defaults, values arbitrary
    localparam logic [6:0] AMR_SMBUS_ADDR_DEFAULT = 7'h2C;
    localparam logic [7:0] AMR_MAKER_ID_DEFAULT = 8'h5A;
    localparam logic [3:0] AMR_REV_MAJOR_DEFAULT = 4'hC;
    localparam logic [3:0] AMR_REV_MINOR_DEFAULT = 4'h0;

    // Serial byte framing
    localparam logic [3:0] AMR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] AMR_CNT_ZERO = 4'h0;
    localparam logic [3:0] AMR_CNT_ONE = 4'h1;

    // Bus slave states, one-hot
    typedef enum logic [8:0] {
        AMR_ST_IDLE     = 9'h001,
        AMR_ST_ADDR     = 9'h002,
        AMR_ST_ADDR_ACK = 9'h004,
        AMR_ST_CMD      = 9'h008,
        AMR_ST_CMD_ACK  = 9'h010,
        AMR_ST_WDATA    = 9'h020,
        AMR_ST_WDAT_ACK = 9'h040,
        AMR_ST_RDATA    = 9'h080,
        AMR_ST_RDAT_ACK = 9'h100
    } amr_state_t;

endpackage : amr_pkg

// ==== sim/amr_alert_mask_props.sv ====
// Port-level checker for the alert mask and identification bank.
module amr_alert_mask_props (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    // Conversion results
    input wire logic i_conv_done,
    input wire logic [7:0] i_fault_temp_supplies,
    input wire logic [7:0] i_fault_analog_inputs,
    input wire logic [7:0] i_fault_fan_tach,
    input wire logic [7:0] i_fault_misc_events,
    input wire logic [7:0] i_fault_io_low,
    input wire logic [7:0] i_fault_io_high,
    // Status and alert
    input wire logic [7:0] o_status_temp_supplies,
    input wire logic [7:0] o_status_analog_inputs,
    input wire logic [7:0] o_status_fan_tach,
    input wire logic [7:0] o_status_misc_events,
    input wire logic [7:0] o_status_io_low,
    input wire logic [7:0] o_status_io_high,
    input wire logic o_alert_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [47:0] all_status;
    assign all_status = {o_status_temp_supplies, o_status_analog_inputs, o_status_fan_tach,
        o_status_misc_events, o_status_io_low, o_status_io_high};
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    property p_cap_temp;
        i_conv_done |=> o_status_temp_supplies == $past(i_fault_temp_supplies);
    endproperty
    a_cap_temp: assert property (p_cap_temp) else $error("temp status capture");
    property p_cap_analog;
        i_conv_done |=> o_status_analog_inputs == $past(i_fault_analog_inputs);
    endproperty
    a_cap_analog: assert property (p_cap_analog) else $error("analog status capture");
    property p_cap_fan;
        i_conv_done |=> o_status_fan_tach == $past(i_fault_fan_tach);
    endproperty
    a_cap_fan: assert property (p_cap_fan) else $error("fan status capture");
    // Unused bit must never show
    property p_cap_misc;
        i_conv_done |=> o_status_misc_events == ($past(i_fault_misc_events) & 8'hDF);
    endproperty
    a_cap_misc: assert property (p_cap_misc) else $error("misc status capture");
    property p_cap_io;
        i_conv_done |=> {o_status_io_high, o_status_io_low} ==
            {$past(i_fault_io_high), $past(i_fault_io_low)};
    endproperty
    a_cap_io: assert property (p_cap_io) else $error("io status capture");
    // Mask writes must not disturb the flags
    property p_hold;
        !i_conv_done |=> $stable(all_status);
    endproperty
    a_hold: assert property (p_hold) else $error("status moved without conversion");
    property p_quiet;
        all_status == 48'h0 |=> o_alert_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("alert without any status");
    property p_reset_clear;
        $fell(i_reset) |-> o_alert_n && all_status == 48'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");
    // Data may only move while the bus clock is low
    property p_drive_low;
        $changed(o_sda_oe_n) |-> !i_scl && o_sda_out == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("data moved with clock high");
endmodule : amr_alert_mask_props

bind amr_alert_mask_regs amr_alert_mask_props u_props (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .i_conv_done(i_conv_done), .i_fault_temp_supplies(i_fault_temp_supplies),
    .i_fault_analog_inputs(i_fault_analog_inputs), .i_fault_fan_tach(i_fault_fan_tach),
    .i_fault_misc_events(i_fault_misc_events), .i_fault_io_low(i_fault_io_low),
    .i_fault_io_high(i_fault_io_high), .o_status_temp_supplies(o_status_temp_supplies),
    .o_status_analog_inputs(o_status_analog_inputs), .o_status_fan_tach(o_status_fan_tach),
    .o_status_misc_events(o_status_misc_events), .o_status_io_low(o_status_io_low),
    .o_status_io_high(o_status_io_high), .o_alert_n(o_alert_n));

// ==== sim/amr_host_model.sv ====
// Management-bus host model, open drain, data high means released.
module amr_host_model
    import amr_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Resolved data wire
    input wire logic i_sda_wire,
    // Host drives
    output logic o_scl,
    output logic o_sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick
    // Data settles mid low phase, sampled late in high phase
    task automatic bit_slot(input logic v, output logic r);
        tick(2);
        o_sda_drv = v;
        tick(3);
        o_scl = 1'b1;
        tick(3);
        r = i_sda_wire;
        tick(1);
        o_scl = 1'b0;
    endtask : bit_slot
    // Start when first is high, stop otherwise
    task automatic edge_cond(input logic first);
        tick(2);
        o_sda_drv = first;
        tick(3);
        o_scl = 1'b1;
        tick(4);
        o_sda_drv = !first;
        tick(4);
        if (first) o_scl = 1'b0;
    endtask : edge_cond
    // Ack slot always released, so a read byte ends in a refusal
    task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], r);
            q[i] = r;
        end
        bit_slot(1'b1, r);
        ack = !r;
    endtask : xfer_byte
    // callers keep clear of the factory test register
    task automatic access(input logic rd, input logic [7:0] ofs, inout logic [7:0] d,
        output logic [7:0] acks);
        logic [7:0] q;
        logic a;
        edge_cond(1'b1);
        xfer_byte({AMR_SMBUS_ADDR_DEFAULT, 1'b0}, q, a);
        acks = 8'(a);
        xfer_byte(ofs, q, a);
        acks = acks + 8'(a);
        if (rd) begin
            edge_cond(1'b1);
            xfer_byte({AMR_SMBUS_ADDR_DEFAULT, 1'b1}, q, a);
            acks = acks + 8'(a);
            xfer_byte(8'hFF, d, a);
        end else begin
            xfer_byte(d, q, a);
            acks = acks + 8'(a);
        end
        edge_cond(1'b0);
    endtask : access
endmodule : amr_host_model

// ==== sim/amr_alert_mask_regs_tb.sv ====
// Self-checking bench for the alert mask and identification bank.
module amr_alert_mask_regs_tb
    import amr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, reset, scl, host_sda, sda_wire, sda_out, sda_oe_n, conv_done, alert_n;
    logic [7:0] fault [6];
    logic [7:0] status [6];
    logic [7:0] mask_m [6];
    logic [7:0] rd_data, acks;
    int failures, cmp_count, cycles, seed;
    assign sda_wire = host_sda & (sda_oe_n | sda_out);
    always #10 ref_clk = ~ref_clk;

    amr_alert_mask_regs u_amr_alert_mask_regs (.i_ref_clk(ref_clk), .i_reset(reset),
        .i_scl(scl), .i_sda(sda_wire), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .i_conv_done(conv_done), .i_fault_temp_supplies(fault[0]),
        .i_fault_analog_inputs(fault[1]), .i_fault_fan_tach(fault[2]),
        .i_fault_misc_events(fault[3]), .i_fault_io_low(fault[4]), .i_fault_io_high(fault[5]),
        .o_status_temp_supplies(status[0]), .o_status_analog_inputs(status[1]),
        .o_status_fan_tach(status[2]), .o_status_misc_events(status[3]),
        .o_status_io_low(status[4]), .o_status_io_high(status[5]), .o_alert_n(alert_n));
    amr_host_model u_host (.i_ref_clk(ref_clk), .i_sda_wire(sda_wire), .o_scl(scl),
        .o_sda_drv(host_sda));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // Hang guard, run needs roughly 35000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            complete_run();
        end
    end
    function automatic logic [7:0] ofs_of(input int r);
        return AMR_OFS_MASK_TEMP_SUPPLIES + 8'(r);
    endfunction : ofs_of
    function automatic logic [7:0] keep(input int r, input logic [7:0] v);
        return (r == 3) ? (v & AMR_MISC_USED_BITS) : v;
    endfunction : keep
    function automatic logic exp_alert_n();
        logic any;
        any = 1'b0;
        for (int r = 0; r < 6; r++) any |= |(keep(r, fault[r]) & ~mask_m[r]);
        return !any;
    endfunction : exp_alert_n
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] t;
        t = d;
        u_host.access(1'b0, ofs, t, acks);
        check(acks, 8'h03);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        u_host.access(1'b1, ofs, rd_data, acks);
        check(acks, 8'h03);
        check(rd_data, exp);
    endtask : rd
    // Status follows faults whatever the mask, alert only on unmasked ones
    task automatic convert;
        conv_done = 1'b1;
        u_host.tick(1);
        conv_done = 1'b0;
        u_host.tick(3);
        for (int r = 0; r < 6; r++) check(status[r], keep(r, fault[r]));
        check({7'h0, alert_n}, {7'h0, exp_alert_n()});
    endtask : convert

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        conv_done = 1'b0;
        seed = 22;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        for (int r = 0; r < 6; r++) begin
            fault[r] = 8'h00;
            mask_m[r] = 8'h00;
        end
        repeat (4) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        u_host.tick(2);
        check({7'h0, alert_n}, 8'h01);
        for (int r = 0; r < 6; r++) rd(ofs_of(r), 8'h00);
        rd(AMR_OFS_MAKER_ID, AMR_MAKER_ID_DEFAULT);
        rd(AMR_OFS_SILICON_REV, {AMR_REV_MAJOR_DEFAULT, AMR_REV_MINOR_DEFAULT});
        // Identity places ignore writes
        wr(AMR_OFS_SILICON_REV, 8'hFF);
        wr(AMR_OFS_MAKER_ID, 8'hA5);
        rd(AMR_OFS_SILICON_REV, {AMR_REV_MAJOR_DEFAULT, AMR_REV_MINOR_DEFAULT});
        rd(AMR_OFS_MAKER_ID, AMR_MAKER_ID_DEFAULT);
        rd(8'h30, AMR_UNMAPPED_READ);
        wr(AMR_OFS_MASK_MISC_EVENTS, 8'hFF);
        rd(AMR_OFS_MASK_MISC_EVENTS, 8'hDF);
        // Each mask bit alone: own fault hidden, neighbour still raises alert unless it is unused misc bit 5
        for (int r = 0; r < 6; r++) begin
            for (int b = 0; b < 8; b++) begin
                mask_m[r] = 8'h01 << b;
                wr(ofs_of(r), mask_m[r]);
                fault[r] = mask_m[r];
                convert();
                fault[r] = mask_m[r] | (8'h01 << ((b + 1) % 8));
                convert();
                fault[r] = 8'h00;
            end
            mask_m[r] = 8'h00;
            wr(ofs_of(r), 8'h00);
        end
        // Random masks and faults
        for (int i = 0; i < 24; i++) begin
            mask_m[i % 6] = 8'($random(seed));
            wr(ofs_of(i % 6), mask_m[i % 6]);
            rd(ofs_of(i % 6), keep(i % 6, mask_m[i % 6]));
            for (int k = 0; k < 6; k++) fault[k] = 8'($random(seed));
            convert();
        end
        complete_run();
    end
endmodule : amr_alert_mask_regs_tb
